// ### verilog/tpm_pkg.sv
// Constants and types for the mid part of the codepoint to priority table
`default_nettype none
package tpm_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] CODEPOINT_PRIORITY_MAP_7 = 8'h67;
  localparam logic [7:0] CODEPOINT_PRIORITY_MAP_8 = 8'h68;
  localparam logic [7:0] CODEPOINT_PRIORITY_MAP_9 = 8'h69;
  localparam logic [7:0] CODEPOINT_PRIORITY_MAP_10 = 8'h6A;
  localparam logic [7:0] CODEPOINT_PRIORITY_MAP_11 = 8'h6B;
  localparam logic [7:0] CODEPOINT_PRIORITY_MAP_12 = 8'h6C;
  localparam logic [7:0] CODEPOINT_PRIORITY_MAP_13 = 8'h6D;
  localparam logic [7:0] CODEPOINT_PRIORITY_MAP_14 = 8'h6E;
  localparam int NUM_REGS = 8;
  localparam int REG_W = 8;
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;
  // Writable bits: all of 0x67..0x6D, only the two upper fields of 0x6E
  localparam logic [REG_W-1:0] REG_MASK_FULL = 8'hFF;
  localparam logic [REG_W-1:0] REG_MASK_LAST = 8'hF0;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int FIELD_W = 2;
  localparam int FIELDS_PER_REG = 4;
  localparam int NUM_FIELDS = NUM_REGS * FIELDS_PER_REG;
  localparam logic [FIELD_W-1:0] FIELD_RESET = 2'h0;
  localparam int TOS_W = 8;
  localparam int CP_MSB = 7;
  localparam int CP_LSB = 2;
  localparam int CP_W = CP_MSB - CP_LSB + 1;
  // Codepoint of TOS byte 0x70, field 0 of the first register
  localparam logic [CP_W-1:0] CP_FIRST = 6'h1C;
  // Fields 28 and 29 (TOS 0xE0, 0xE4) sit in 0x6E but are not held here
  localparam logic [NUM_FIELDS-1:0] FIELD_OWNED = 32'hCFFF_FFFF;

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef struct packed {
    logic [NUM_REGS-1:0][REG_W-1:0] regs;
    logic [REG_W-1:0] rdata;
    logic rack;
    logic rhit;
    logic wack;
  } tpm_bank_state_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [FIELD_W-1:0] prio;
  } tpm_lookup_state_t;

endpackage
`default_nettype wire

// ### verilog/tpm_lookup.sv
// Codepoint to priority lookup stage for the mid part of the table
`timescale 1ns/100ps
`default_nettype none
module tpm_lookup #(
  parameter int NUM_FIELDS = tpm_pkg::NUM_FIELDS
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Table contents
  input wire logic [NUM_FIELDS*tpm_pkg::FIELD_W-1:0] table_i,
  // Frame side
  input wire logic frame_valid_i,
  input wire logic [tpm_pkg::TOS_W-1:0] tos_i,
  // Result
  output logic prio_valid_o,
  output logic prio_hit_o,
  output logic [tpm_pkg::FIELD_W-1:0] prio_o
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (NUM_FIELDS != tpm_pkg::NUM_FIELDS) begin : g_bad_fields
    $error("tpm_lookup: NUM_FIELDS must match the table size");
  end

  tpm_pkg::tpm_lookup_state_t s_q;
  tpm_pkg::tpm_lookup_state_t s_d;
  logic [tpm_pkg::CP_W-1:0] cp;
  logic [tpm_pkg::CP_W-1:0] idx_full;
  logic [4:0] idx;
  logic in_range;

  // ****************************************************************
  // Lookup
  // ****************************************************************
  always_comb begin
    cp = tos_i[tpm_pkg::CP_MSB:tpm_pkg::CP_LSB];
    idx_full = cp - tpm_pkg::CP_FIRST;
    idx = idx_full[4:0];
    // Only codepoints 0x1C..0x3B land in this part of the table
    in_range = (cp >= tpm_pkg::CP_FIRST) && (idx_full < 6'h20);
    s_d = s_q;
    s_d.valid = frame_valid_i;
    s_d.hit = frame_valid_i && in_range && tpm_pkg::FIELD_OWNED[idx];
    s_d.prio = tpm_pkg::FIELD_RESET;
    if (s_d.hit) begin
      s_d.prio = table_i[idx*tpm_pkg::FIELD_W +: tpm_pkg::FIELD_W];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prio_valid_o = s_q.valid;
  assign prio_hit_o = s_q.hit;
  assign prio_o = s_q.prio;

endmodule
`default_nettype wire

// ### verilog/tpm_priority_map.sv
// Register bank of codepoint priority fields, TOS bytes 0x70 to 0xEC
`timescale 1ns/100ps
`default_nettype none
module tpm_priority_map (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Management register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [tpm_pkg::REG_W-1:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [tpm_pkg::REG_W-1:0] reg_rdata_o,
  output logic reg_rack_o,
  output logic reg_hit_o,
  output logic reg_wack_o,
  // Frame classification
  input wire logic frame_valid_i,
  input wire logic [tpm_pkg::TOS_W-1:0] tos_i,
  output logic prio_valid_o,
  output logic prio_hit_o,
  output logic [tpm_pkg::FIELD_W-1:0] prio_o
);

  tpm_pkg::tpm_bank_state_t s_q;
  tpm_pkg::tpm_bank_state_t s_d;
  logic [tpm_pkg::NUM_FIELDS*tpm_pkg::FIELD_W-1:0] table_flat;
  logic sel_hit;
  logic [2:0] sel_idx;
  logic [tpm_pkg::REG_W-1:0] sel_mask;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  always_comb begin
    sel_hit = 1'b1;
    sel_idx = 3'h0;
    sel_mask = tpm_pkg::REG_MASK_FULL;
    if (reg_addr_i == tpm_pkg::CODEPOINT_PRIORITY_MAP_7) begin
      sel_idx = 3'h0;
    end else if (reg_addr_i == tpm_pkg::CODEPOINT_PRIORITY_MAP_8) begin
      sel_idx = 3'h1;
    end else if (reg_addr_i == tpm_pkg::CODEPOINT_PRIORITY_MAP_9) begin
      sel_idx = 3'h2;
    end else if (reg_addr_i == tpm_pkg::CODEPOINT_PRIORITY_MAP_10) begin
      sel_idx = 3'h3;
    end else if (reg_addr_i == tpm_pkg::CODEPOINT_PRIORITY_MAP_11) begin
      sel_idx = 3'h4;
    end else if (reg_addr_i == tpm_pkg::CODEPOINT_PRIORITY_MAP_12) begin
      sel_idx = 3'h5;
    end else if (reg_addr_i == tpm_pkg::CODEPOINT_PRIORITY_MAP_13) begin
      sel_idx = 3'h6;
    end else if (reg_addr_i == tpm_pkg::CODEPOINT_PRIORITY_MAP_14) begin
      sel_idx = 3'h7;
      // Low half of this byte belongs to the neighbouring bank
      sel_mask = tpm_pkg::REG_MASK_LAST;
    end else begin
      sel_hit = 1'b0;
    end
  end

  // ****************************************************************
  // Register file and read path
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.rack = reg_rd_i;
    s_d.wack = reg_wr_i && sel_hit;
    s_d.rhit = (reg_rd_i || reg_wr_i) && sel_hit;
    s_d.rdata = s_q.rdata;
    if (reg_wr_i && sel_hit) begin
      s_d.regs[sel_idx] = (reg_wdata_i & sel_mask) | (s_q.regs[sel_idx] & ~sel_mask);
    end
    if (reg_rd_i) begin
      // Unclaimed addresses and bits read as zero so a neighbour can OR in
      if (sel_hit) begin
        s_d.rdata = s_q.regs[sel_idx] & sel_mask;
      end else begin
        s_d.rdata = tpm_pkg::REG_RESET;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_q.regs <= {tpm_pkg::NUM_REGS{tpm_pkg::REG_RESET}};
      s_q.rdata <= tpm_pkg::REG_RESET;
      s_q.rack <= 1'b0;
      s_q.rhit <= 1'b0;
      s_q.wack <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign reg_rack_o = s_q.rack;
  assign reg_hit_o = s_q.rhit;
  assign reg_wack_o = s_q.wack;

  // ****************************************************************
  // Table flattening, field i of register r at index 4r+i
  // ****************************************************************
  for (genvar r = 0; r < tpm_pkg::NUM_REGS; r++) begin : g_flat
    assign table_flat[r*tpm_pkg::REG_W +: tpm_pkg::REG_W] = s_q.regs[r];
  end

  // ****************************************************************
  // Classification
  // ****************************************************************
  tpm_lookup #(
    .NUM_FIELDS(tpm_pkg::NUM_FIELDS)
  ) tpm_lookup_inst (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .table_i(table_flat),
    .frame_valid_i(frame_valid_i),
    .tos_i(tos_i),
    .prio_valid_o(prio_valid_o),
    .prio_hit_o(prio_hit_o),
    .prio_o(prio_o)
  );

endmodule
`default_nettype wire

// ### verif/tpm_priority_map_checker.sv
// Concurrent checks on the register port and lookup of the priority map
`timescale 1ns/100ps
`default_nettype none
module tpm_priority_map_checker (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [tpm_pkg::REG_W-1:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [tpm_pkg::REG_W-1:0] reg_rdata_o,
  input wire logic reg_rack_o,
  input wire logic reg_hit_o,
  input wire logic reg_wack_o,
  // Lookup
  input wire logic frame_valid_i,
  input wire logic [tpm_pkg::TOS_W-1:0] tos_i,
  input wire logic prio_valid_o,
  input wire logic prio_hit_o,
  input wire logic [tpm_pkg::FIELD_W-1:0] prio_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic in_bank;
  logic in_map;
  assign in_bank = reg_addr_i inside {[8'h67:8'h6E]};
  assign in_map = tos_i inside {[8'h70:8'hDF], [8'hE8:8'hEF]};
  // ****************************************************************
  // Checks
  // ****************************************************************
  a_read_answer: assert property (reg_rd_i |=> reg_rack_o)
    else $error("read not answered");
  a_no_idle_answer: assert property (!reg_rd_i |=> !reg_rack_o)
    else $error("answer without read");
  a_write_hit: assert property (reg_wr_i && in_bank |=> reg_wack_o && reg_hit_o)
    else $error("write to bank not acknowledged");
  a_unmapped_miss: assert property ((reg_rd_i || reg_wr_i) && !in_bank
    |=> !reg_hit_o && !reg_wack_o)
    else $error("unmapped access hit");
  a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  a_write_readback: assert property (
    reg_wr_i && reg_addr_i inside {[8'h67:8'h6D]} ##1 !reg_wr_i
    ##1 reg_rd_i && !reg_wr_i && reg_addr_i == $past(reg_addr_i, 2)
    |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("written value not read back");
  a_lookup_latency: assert property (frame_valid_i |=> prio_valid_o)
    else $error("lookup not answered");
  a_lookup_idle: assert property (!frame_valid_i |=> !prio_valid_o)
    else $error("lookup answer without request");
  a_lookup_hit: assert property (frame_valid_i |=> prio_hit_o == $past(in_map))
    else $error("lookup hit wrong");
  a_miss_zero: assert property (frame_valid_i && !in_map |=> prio_o == 2'h0)
    else $error("priority not zero on miss");
  cover property (reg_wr_i && reg_rd_i);
  cover property (frame_valid_i && in_map);
  cover property (reg_rd_i && !in_bank);
  cover property (reg_wr_i && reg_addr_i == 8'h6E);
endmodule
bind tpm_priority_map tpm_priority_map_checker tpm_priority_map_checker_inst (.core_clk_i,
  .reset_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rack_o,
  .reg_hit_o, .reg_wack_o, .frame_valid_i, .tos_i, .prio_valid_o, .prio_hit_o, .prio_o);
`default_nettype wire

// ### verif/tpm_priority_map_tb.sv
// Self-checking bench for the codepoint priority register bank
`timescale 1ns/100ps
`default_nettype none
module tpm_priority_map_tb;
  logic core_clk_i, reset_i, reg_wr_i, reg_rd_i, frame_valid_i;
  logic [7:0] reg_addr_i, reg_wdata_i, tos_i, reg_rdata_o;
  logic reg_rack_o, reg_hit_o, reg_wack_o, prio_valid_o, prio_hit_o;
  logic [1:0] prio_o;
  logic [7:0] mdl [8];
  int fail_count = 0;
  int tests_run = 0;
  tpm_priority_map tpm_priority_map_inst (.core_clk_i, .reset_i, .reg_addr_i, .reg_wr_i,
    .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rack_o, .reg_hit_o, .reg_wack_o,
    .frame_valid_i, .tos_i, .prio_valid_o, .prio_hit_o, .prio_o);
  initial begin
    core_clk_i = 0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  task chk(input logic [7:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One register access; the strobes drop one cycle later
  task acc(input logic w, r, input logic [7:0] a, d);
    logic hit;
    logic [7:0] exp;
    hit = a inside {[8'h67:8'h6E]};
    exp = hit ? mdl[a - 8'h67] : 8'h00;
    @(posedge core_clk_i);
    #1;
    reg_wr_i = w;
    reg_rd_i = r;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(posedge core_clk_i);
    #1;
    reg_wr_i = 0;
    reg_rd_i = 0;
    chk(8'({reg_rack_o, reg_wack_o, reg_hit_o}), 8'({r, w & hit, hit}), "ack");
    if (r) chk(reg_rdata_o, exp, "rdata");
    if (w && hit) mdl[a - 8'h67] = d & (a == 8'h6E ? 8'hF0 : 8'hFF);
  endtask
  task lk(input logic [7:0] t);
    logic [5:0] i;
    logic hit;
    logic [1:0] p;
    i = t[7:2] - 6'h1C;
    hit = t inside {[8'h70:8'hDF], [8'hE8:8'hEF]};
    p = hit ? mdl[i[5:2]][i[1:0] * 2 +: 2] : 2'h0;
    @(posedge core_clk_i);
    #1;
    frame_valid_i = 1;
    tos_i = t;
    @(posedge core_clk_i);
    #1;
    frame_valid_i = 0;
    chk(8'({prio_valid_o, prio_hit_o, prio_o}), 8'({1'b1, hit, p}), "lookup");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    $display("[FAIL] %0t timeout", $time);
    summarize;
  end
  initial begin
    reset_i = 1;
    reg_wr_i = 0;
    reg_rd_i = 0;
    frame_valid_i = 0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    tos_i = 8'h00;
    foreach (mdl[k]) mdl[k] = 8'h00;
    repeat (16) @(posedge core_clk_i);
    #1 reset_i = 0;
    for (int a = 8'h65; a < 8'h71; a++) acc(0, 1, 8'(a), 8'h00);
    for (int a = 8'h66; a < 8'h70; a++) begin
      acc(1, 0, 8'(a), 8'(a * 37));
      acc(0, 1, 8'(a), 8'h00);
    end
    acc(1, 1, 8'h6B, 8'h5A);
    acc(0, 1, 8'h6B, 8'h00);
    for (int t = 0; t < 256; t++) lk(8'(t));
    reset_i = 1;
    repeat (2) @(posedge core_clk_i);
    #1 reset_i = 0;
    foreach (mdl[k]) mdl[k] = 8'h00;
    acc(0, 1, 8'h6E, 8'h00);
    lk(8'hDC);
    summarize;
  end
endmodule
`default_nettype wire
